//--- design/pulse_count_led_programming.sv
// One-wire pulse-count register programming and pump-ratio sequencing
// Function
// R1 - First high enables, all currents zero
// R2 - Low 1.5 ms requests shutdown
// R3 - Shutdown clears every register
// R4 - Current sources off about 1 ms later; code turns them off at shutdown and drops ENABLED after PWRDN_CYCLES
// R5 - Shutdown makes LED outputs high impedance
// R6 - Undervoltage disables channels, resets registers
// R7 - Five 4-bit registers, one 1-bit register; code stores register six as 4 bits and decodes the lock from value 15
// R8 - Address burst then separate data burst
// R9 - N falling edges select register N
// R10 - Host keeps phases 200 ns to 100 us
// R11 - Pulses under 200 ns ignored
// R12 - Host waits 500-1000 us before data
// R13 - No data within 1000 us aborts
// R14 - Addressing a register clears it
// R15 - Host waits 1.5 ms after data
// R16 - Host waits 2 ms after failure
// R17 - Await address; host allows 10 us setup
// R18 - Host waits 2 ms if idle
// R19 - Pump starts and stays at 1x
// R20 - Lost regulation steps to 1.33x after filter
// R21 - Then 1.5x, 2x, same delay
// R22 - Unity sufficient returns directly to 1x
// R23 - Data N stores (16-N) mod 16
// R24 - Register one: range and bank enables
// R25 - Register six: one pulse sets lock
// R26 - Addressing register six restarts pump at 1x
// R27 - Line synchronised, durations counted by clock
`timescale 1ns/1ps
`default_nettype none
module pulse_count_led_programming #(
    parameter int OFF_CYCLES = pulse_led_pkg::OFF_CYC,
    parameter int PWRDN_CYCLES = pulse_led_pkg::PWRDN_CYC,
    parameter int GAP_CYCLES = pulse_led_pkg::GAP_CYC,
    parameter int BURST_END_CYCLES = pulse_led_pkg::BURST_END_CYC,
    parameter int FILTER_CYCLES = pulse_led_pkg::FILTER_CYC,
    parameter int SETUP_CYCLES = pulse_led_pkg::SETUP_CYC
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic EN_SET,
    input wire logic SUPPLY_LOW_LOCKOUT,
    input wire logic REGULATION_LOST,
    input wire logic UNITY_SUFFICIENT,
    output pulse_led_pkg::led_settings_t SETTINGS,
    output logic ENABLED,
    output logic SOURCES_ON,
    output logic LED_HIGH_Z,
    output pulse_led_pkg::ratio_t PUMP_RATIO
);
    localparam int TW = pulse_led_pkg::TMR_W;
    localparam int CW = pulse_led_pkg::CNT_W;
    localparam int RW = pulse_led_pkg::REG_W;

    // Four-bit value stored for a burst of n pulses
    function automatic logic [3:0] pulse_value(input logic [CW-1:0] n);
        logic [CW-1:0] v;
        v = 5'h10 - n;
        return v[RW-1:0];
    endfunction

    logic sync1;
    logic sync2;
    logic line;
    logic line_prev;
    logic [TW-1:0] glitch_cnt;
    logic [TW-1:0] low_cnt;
    logic [TW-1:0] timer;
    logic [TW-1:0] filt_cnt;
    logic [CW-1:0] edge_cnt;
    logic [2:0] addr;
    logic [RW-1:0] regs [1:pulse_led_pkg::NUM_REGS];
    logic lock_bit;
    logic fall;
    logic rise;
    logic long_low;
    logic pump_restart;
    pulse_led_pkg::link_state_t state;

    // Two-stage synchroniser on the control line [R27]
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end
        else
        begin
            sync1 <= EN_SET;
            sync2 <= sync1;
        end
    end

    // Deglitch: accept a new level only after it holds 200 ns [R11]
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            line <= 1'b0;
            glitch_cnt <= '0;
        end
        else if (sync2 == line)
            glitch_cnt <= '0;
        else if (glitch_cnt >= TW'(pulse_led_pkg::GLITCH_CYC - 1))
        begin
            line <= sync2;
            glitch_cnt <= '0;
        end
        else
            glitch_cnt <= glitch_cnt + 1'b1;
    end

    // Edge detect on the filtered line
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            line_prev <= 1'b0;
        else
            line_prev <= line;
    end
    assign fall = line_prev & ~line; // [R9]
    assign rise = ~line_prev & line;

    // Continuous low time, for shutdown detection [R2] [R27]
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            low_cnt <= '0;
        else if (line)
            low_cnt <= '0;
        else if (low_cnt < TW'(OFF_CYCLES))
            low_cnt <= low_cnt + 1'b1;
    end
    assign long_low = (low_cnt >= TW'(OFF_CYCLES)) && state != pulse_led_pkg::ST_OFF
        && state != pulse_led_pkg::ST_PWRDN;

    // Link state machine and its timer [R8] [R13] [R17]
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state <= pulse_led_pkg::ST_OFF;
            timer <= '0;
            edge_cnt <= '0;
            addr <= '0;
        end
        else if (SUPPLY_LOW_LOCKOUT)
        begin
            state <= pulse_led_pkg::ST_OFF; // [R6]
            timer <= '0;
            edge_cnt <= '0;
        end
        else if (long_low)
        begin
            state <= pulse_led_pkg::ST_PWRDN; // [R2]
            timer <= '0;
            edge_cnt <= '0;
        end
        else
        begin
            case (state)
                pulse_led_pkg::ST_OFF:
                    if (rise)
                    begin
                        state <= pulse_led_pkg::ST_INIT; // [R1]
                        timer <= '0;
                    end
                pulse_led_pkg::ST_INIT:
                    if (timer >= TW'(SETUP_CYCLES - 1))
                    begin
                        state <= pulse_led_pkg::ST_ADDR; // [R17]
                        timer <= '0;
                        edge_cnt <= '0;
                    end
                    else
                        timer <= timer + 1'b1;
                pulse_led_pkg::ST_ADDR:
                    if (fall)
                    begin
                        edge_cnt <= (edge_cnt == CW'(pulse_led_pkg::NUM_REGS))
                            ? edge_cnt : edge_cnt + 1'b1; // [R9]
                        timer <= '0;
                    end
                    else if (line && edge_cnt != '0)
                    begin
                        if (timer >= TW'(BURST_END_CYCLES - 1))
                        begin
                            state <= pulse_led_pkg::ST_GAP; // [R8]
                            addr <= edge_cnt[2:0];
                            edge_cnt <= '0;
                            timer <= '0;
                        end
                        else
                            timer <= timer + 1'b1;
                    end
                pulse_led_pkg::ST_GAP:
                    if (fall)
                    begin
                        state <= pulse_led_pkg::ST_DATA;
                        edge_cnt <= 5'h01;
                        timer <= '0;
                    end
                    else if (timer >= TW'(GAP_CYCLES - 1))
                    begin
                        state <= pulse_led_pkg::ST_ADDR; // [R13]
                        timer <= '0;
                    end
                    else
                        timer <= timer + 1'b1;
                pulse_led_pkg::ST_DATA:
                    if (fall)
                    begin
                        edge_cnt <= (edge_cnt == 5'h10) ? edge_cnt : edge_cnt + 1'b1;
                        timer <= '0;
                    end
                    else if (line && timer >= TW'(BURST_END_CYCLES - 1))
                    begin
                        state <= pulse_led_pkg::ST_ADDR;
                        edge_cnt <= '0;
                        timer <= '0;
                    end
                    else if (line)
                        timer <= timer + 1'b1;
                pulse_led_pkg::ST_PWRDN:
                    if (timer >= TW'(PWRDN_CYCLES - 1))
                        state <= pulse_led_pkg::ST_OFF; // [R4]
                    else
                        timer <= timer + 1'b1;
                default:
                    state <= pulse_led_pkg::ST_OFF;
            endcase
        end
    end

    // Register file: cleared on select, written at burst end [R7] [R14] [R23]
    for (genvar i = 1; i <= pulse_led_pkg::NUM_REGS; i++)
    begin : g_reg
        always_ff @(posedge CLK or negedge RESETN)
        begin
            if (!RESETN)
                regs[i] <= '0;
            else if (SUPPLY_LOW_LOCKOUT || long_low || state == pulse_led_pkg::ST_OFF)
                regs[i] <= '0; // [R3] [R6]
            else if (state == pulse_led_pkg::ST_ADDR && line && edge_cnt == CW'(i)
                && timer >= TW'(BURST_END_CYCLES - 1))
                regs[i] <= '0; // [R14]
            else if (state == pulse_led_pkg::ST_DATA && addr == 3'(i) && line && !fall
                && timer >= TW'(BURST_END_CYCLES - 1))
                regs[i] <= pulse_value(edge_cnt); // [R23]
        end
    end

    // Register six keeps four bits; lock is decoded from value 15, which a single pulse stores [R25]
    assign lock_bit = (regs[pulse_led_pkg::NUM_REGS] == 4'hF);

    // Settings outputs [R24]
    always_comb
    begin
        SETTINGS.current_range_select = regs[1][pulse_led_pkg::RANGE_BIT];
        SETTINGS.bank_a_on = regs[1][pulse_led_pkg::BANK_A_BIT];
        SETTINGS.bank_b_on = regs[1][pulse_led_pkg::BANK_B_BIT];
        SETTINGS.bank_c_on = regs[1][pulse_led_pkg::BANK_C_BIT];
        SETTINGS.global_current = regs[2];
        SETTINGS.bank_a_current = regs[3];
        SETTINGS.bank_b_current = regs[4];
        SETTINGS.bank_c_current = regs[5];
        SETTINGS.unity_return_lock = lock_bit;
    end

    // Enable and output status [R1] [R5]
    assign ENABLED = state != pulse_led_pkg::ST_OFF;
    assign SOURCES_ON = ENABLED && state != pulse_led_pkg::ST_PWRDN && !SUPPLY_LOW_LOCKOUT;
    assign LED_HIGH_Z = !SOURCES_ON; // [R5]

    // Pump restart when register six is selected [R26]
    assign pump_restart = state == pulse_led_pkg::ST_ADDR && line
        && edge_cnt == CW'(pulse_led_pkg::ADDR_LOCK) && timer >= TW'(BURST_END_CYCLES - 1);

    // Pump ratio sequencer with filter delay [R19] [R20] [R21] [R22]
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            PUMP_RATIO <= pulse_led_pkg::RATIO_1X;
            filt_cnt <= '0;
        end
        else if (!SOURCES_ON || pump_restart)
        begin
            PUMP_RATIO <= pulse_led_pkg::RATIO_1X; // [R19] [R26]
            filt_cnt <= '0;
        end
        else if (UNITY_SUFFICIENT && !lock_bit && PUMP_RATIO != pulse_led_pkg::RATIO_1X)
        begin
            PUMP_RATIO <= pulse_led_pkg::RATIO_1X; // [R22] [R25]
            filt_cnt <= '0;
        end
        else if (REGULATION_LOST && PUMP_RATIO != pulse_led_pkg::RATIO_2X)
        begin
            if (filt_cnt >= TW'(FILTER_CYCLES - 1))
            begin
                filt_cnt <= '0;
                case (PUMP_RATIO)
                    pulse_led_pkg::RATIO_1X: PUMP_RATIO <= pulse_led_pkg::RATIO_1P33X; // [R20]
                    pulse_led_pkg::RATIO_1P33X: PUMP_RATIO <= pulse_led_pkg::RATIO_1P5X; // [R21]
                    pulse_led_pkg::RATIO_1P5X: PUMP_RATIO <= pulse_led_pkg::RATIO_2X;
                    default: PUMP_RATIO <= pulse_led_pkg::RATIO_2X;
                endcase
            end
            else
                filt_cnt <= filt_cnt + 1'b1;
        end
        else
            filt_cnt <= '0;
    end
endmodule
`default_nettype wire

//--- design/pulse_led_pkg.sv
// Package with constants and types for the pulse-count LED programming block
`default_nettype none
package pulse_led_pkg;
    localparam int CLK_MHZ = 100;
    localparam int GLITCH_NS = 200;
    localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int OFF_US = 1500;
    localparam int OFF_CYC = OFF_US * CLK_MHZ;
    localparam int PWRDN_US = 1000;
    localparam int PWRDN_CYC = PWRDN_US * CLK_MHZ;
    localparam int GAP_US = 1000;
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    localparam int BURST_END_US = 100;
    localparam int BURST_END_CYC = BURST_END_US * CLK_MHZ;
    localparam int FILTER_US = 400;
    localparam int FILTER_CYC = FILTER_US * CLK_MHZ;
    localparam int SETUP_US = 10;
    localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
    localparam int NUM_REGS = 6;
    localparam int REG_W = 4;
    localparam int CNT_W = 5;
    localparam int TMR_W = 24;
    localparam logic [2:0] ADDR_LOCK = 3'h6;
    localparam int RANGE_BIT = 3;
    localparam int BANK_A_BIT = 2;
    localparam int BANK_B_BIT = 1;
    localparam int BANK_C_BIT = 0;

    // Pump ratio, one-hot
    typedef enum logic [3:0] {
        RATIO_1X = 4'h1,
        RATIO_1P33X = 4'h2,
        RATIO_1P5X = 4'h4,
        RATIO_2X = 4'h8
    } ratio_t;

    // Link state, one-hot
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_INIT = 6'h02,
        ST_ADDR = 6'h04,
        ST_GAP = 6'h08,
        ST_DATA = 6'h10,
        ST_PWRDN = 6'h20
    } link_state_t;

    // Settings handed to the analog side
    typedef struct packed {
        logic current_range_select;
        logic bank_a_on;
        logic bank_b_on;
        logic bank_c_on;
        logic [3:0] global_current;
        logic [3:0] bank_a_current;
        logic [3:0] bank_b_current;
        logic [3:0] bank_c_current;
        logic unity_return_lock;
    } led_settings_t;
endpackage
`default_nettype wire

//--- verif/led_prog_monitor.sv
// Checker for the pulse-count LED programming block
`timescale 1ns/1ps
`default_nettype none
module led_prog_monitor #(
    parameter int FILTER_CYCLES = 40
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic EN_SET,
    input wire logic SUPPLY_LOW_LOCKOUT,
    input wire logic REGULATION_LOST,
    input wire logic UNITY_SUFFICIENT,
    input wire pulse_led_pkg::led_settings_t SETTINGS,
    input wire logic ENABLED,
    input wire logic SOURCES_ON,
    input wire logic LED_HIGH_Z,
    input wire pulse_led_pkg::ratio_t PUMP_RATIO
);
    int lost_cnt;
    logic [3:0] prev_ratio;
    logic prev_lock;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Cycles of lost regulation since the last ratio change
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            lost_cnt <= 0;
            prev_ratio <= 4'h1;
            prev_lock <= 1'b0;
        end
        else
        begin
            prev_ratio <= PUMP_RATIO;
            prev_lock <= SETTINGS.unity_return_lock;
            if (!REGULATION_LOST || UNITY_SUFFICIENT || !SOURCES_ON || PUMP_RATIO != prev_ratio)
                lost_cnt <= 0;
            else if (lost_cnt < 100000)
                lost_cnt <= lost_cnt + 1;
        end
    end
    off_quiet_a: assert property (!ENABLED |-> SETTINGS == '0 && LED_HIGH_Z)
        else $error("settings or sources active while off");
    supply_low_lockout_off_a: assert property (SUPPLY_LOW_LOCKOUT |-> !SOURCES_ON && LED_HIGH_Z)
        else $error("sources on during undervoltage");
    supply_low_lockout_clear_a: assert property (SUPPLY_LOW_LOCKOUT [*3] |-> SETTINGS == '0)
        else $error("settings kept during undervoltage");
    single_step_a: assert property (
        PUMP_RATIO != prev_ratio && PUMP_RATIO != 4'h1 |-> PUMP_RATIO == {prev_ratio[2:0], 1'b0})
        else $error("ratio skipped a step");
    step_filter_a: assert property (
        PUMP_RATIO != prev_ratio && PUMP_RATIO != 4'h1 |-> lost_cnt >= FILTER_CYCLES - 3)
        else $error("ratio stepped before filter delay");
    step_bound_a: assert property (lost_cnt <= FILTER_CYCLES + 6 || PUMP_RATIO == 4'h8)
        else $error("ratio step overdue");
    unity_return_a: assert property (
        UNITY_SUFFICIENT && !SETTINGS.unity_return_lock && SOURCES_ON |-> ##[0:3] PUMP_RATIO == 4'h1)
        else $error("no return to unity");
    lock_hold_a: assert property (
        prev_lock && SETTINGS.unity_return_lock && SOURCES_ON |-> !(PUMP_RATIO == 4'h1
        && prev_ratio != 4'h1)) else $error("return to unity while locked");
    off_pump_a: assert property (!SOURCES_ON [*2] |-> PUMP_RATIO == 4'h1)
        else $error("pump not at unity while off");
    cover property (PUMP_RATIO == 4'h8);
    cover property (SETTINGS.unity_return_lock);
    cover property (ENABLED && !SOURCES_ON);
endmodule
bind pulse_count_led_programming led_prog_monitor #(.FILTER_CYCLES(FILTER_CYCLES)) u_mon (
    .CLK(CLK), .RESETN(RESETN), .EN_SET(EN_SET), .SUPPLY_LOW_LOCKOUT(SUPPLY_LOW_LOCKOUT),
    .REGULATION_LOST(REGULATION_LOST), .UNITY_SUFFICIENT(UNITY_SUFFICIENT),
    .SETTINGS(SETTINGS), .ENABLED(ENABLED), .SOURCES_ON(SOURCES_ON),
    .LED_HIGH_Z(LED_HIGH_Z), .PUMP_RATIO(PUMP_RATIO));
`default_nettype wire

//--- verif/pulse_host.sv
// Host model driving the one-wire control line
`timescale 1ns/1ps
`default_nettype none
module pulse_host (
    input wire logic clk,
    output var logic en_set
);
    initial en_set = 1'b0;
    // Raise the line and allow the setup time
    task automatic rise;
        @(posedge clk);
        en_set <= 1'b1;
        repeat (20) @(posedge clk);
    endtask
    // Low and high phases of equal length
    task automatic burst(input int n, input int w);
        repeat (n)
        begin
            en_set <= 1'b0;
            repeat (w) @(posedge clk);
            en_set <= 1'b1;
            repeat (w) @(posedge clk);
        end
    endtask
    // Optional short glitch, address, gap, data, then quiet time
    task automatic prog(input int a, input int d, input bit g);
        @(posedge clk);
        if (g)
            burst(1, 5);
        burst(a, 30);
        repeat (150) @(posedge clk);
        burst(d, 30);
        repeat (d == 0 ? 550 : 350) @(posedge clk);
    endtask
    task automatic hold_low(input int n);
        @(posedge clk);
        en_set <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the pulse-count LED programming block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
    localparam int FILT = 40;
    localparam int OFFC = 300;
    localparam int PDNC = 200;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic en_set;
    logic supply_low_lockout = 1'b0;
    logic reg_lost = 1'b0;
    logic unity_ok = 1'b0;
    pulse_led_pkg::led_settings_t settings;
    logic enabled;
    logic src_on;
    logic high_z;
    pulse_led_pkg::ratio_t ratio;
    int mismatches = 0;
    int tests_run = 0;
    logic [20:0] exp_set = '0;
    always #5 clk = ~clk;
    pulse_host u_host (.clk(clk), .en_set(en_set));
    pulse_count_led_programming #(.OFF_CYCLES(OFFC), .PWRDN_CYCLES(PDNC), .GAP_CYCLES(250),
        .BURST_END_CYCLES(50), .FILTER_CYCLES(FILT), .SETUP_CYCLES(5)) u_dut (
        .CLK(clk), .RESETN(resetn), .EN_SET(en_set), .SUPPLY_LOW_LOCKOUT(supply_low_lockout),
        .REGULATION_LOST(reg_lost), .UNITY_SUFFICIENT(unity_ok), .SETTINGS(settings),
        .ENABLED(enabled), .SOURCES_ON(src_on), .LED_HIGH_Z(high_z), .PUMP_RATIO(ratio));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // Wait for the next ratio step and judge its delay
    task automatic step_to(input logic [3:0] nxt);
        logic [3:0] old;
        int n;
        old = ratio;
        n = 0;
        while (ratio === old && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("ratio", nxt, ratio)
        `CHK("filter", 1'b1, n >= FILT - 3 && n <= FILT + 6)
    endtask
    task automatic lose(input logic v);
        @(posedge clk);
        reg_lost <= v;
        @(negedge clk);
    endtask
    task automatic t_start;
        u_host.rise();
        settle(40);
        `CHK("enabled", 1'b1, enabled)
        `CHK("settings", 21'h0, settings)
        `CHK("ratio", 4'h1, ratio)
        $display("done start");
    endtask
    task automatic t_write;
        int dat[5] = '{9, 1, 3, 0, 15};
        for (int a = 1; a <= 5; a++)
        begin
            u_host.prog(a, dat[a-1], 1'b0);
            exp_set[24-4*a -: 4] = 4'((16 - dat[a-1]) % 16);
        end
        settle(0);
        `CHK("settings", exp_set, settings)
        `CHK("range", 1'b0, settings.current_range_select)
        `CHK("bank c", 1'b1, settings.bank_c_on)
        u_host.prog(2, 2, 1'b1);
        exp_set[16 -: 4] = 4'hE;
        u_host.prog(5, 0, 1'b0);
        exp_set[4 -: 4] = 4'h0;
        settle(0);
        `CHK("settings", exp_set, settings)
        $display("done write");
    endtask
    task automatic t_pump;
        lose(1'b1);
        step_to(4'h2);
        step_to(4'h4);
        @(posedge clk);
        reg_lost <= 1'b0;
        unity_ok <= 1'b1;
        settle(5);
        `CHK("unity return", 4'h1, ratio)
        @(posedge clk);
        unity_ok <= 1'b0;
        u_host.prog(6, 1, 1'b0);
        settle(0);
        `CHK("lock", 1'b1, settings.unity_return_lock)
        lose(1'b1);
        step_to(4'h2);
        step_to(4'h4);
        step_to(4'h8);
        @(posedge clk);
        reg_lost <= 1'b0;
        unity_ok <= 1'b1;
        settle(10);
        `CHK("locked", 4'h8, ratio)
        @(posedge clk);
        unity_ok <= 1'b0;
        u_host.prog(6, 2, 1'b0);
        settle(0);
        `CHK("restart", 4'h1, ratio)
        `CHK("lock", 1'b0, settings.unity_return_lock)
        $display("done pump");
    endtask
    task automatic t_off;
        u_host.hold_low(OFFC - 10);
        settle(0);
        `CHK("early", 1'b1, src_on)
        settle(50);
        `CHK("shut", 1'b0, src_on)
        `CHK("cleared", 21'h0, settings)
        `CHK("powering", 1'b1, enabled)
        settle(PDNC);
        `CHK("enabled", 1'b0, enabled)
        `CHK("high z", 1'b1, high_z)
        u_host.rise();
        u_host.prog(2, 1, 1'b0);
        settle(0);
        `CHK("reprogram", 21'h1E000, settings)
        `CHK("re-enabled", 1'b1, src_on)
        @(posedge clk);
        supply_low_lockout <= 1'b1;
        settle(3);
        `CHK("supply_low_lockout src", 1'b0, src_on)
        `CHK("supply_low_lockout set", 21'h0, settings)
        @(posedge clk);
        supply_low_lockout <= 1'b0;
        $display("done off");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        t_start;
        t_write;
        t_pump;
        t_off;
        end_of_test;
    end
    initial
    begin
        #800000;
        mismatches++;
        end_of_test;
    end
endmodule
`default_nettype wire
